// file: arpd_ctrl.sv
// control logic: dac register, sequence position, power-down, soft reset
`timescale 1ns/1ps
module arpd_ctrl
    import arpd_pkg::*;
#(
    parameter int DEEP_WAKE = DEEP_WAKE_CYC
)(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // parallel interface
    input  wire logic                  wr_n,
    input  wire logic                  rd_n,
    input  wire logic [DB_W-1:0]       db_in,
    output logic      [DB_W-1:0]       db_out,
    output logic                       db_oe,
    // conversion
    input  wire logic                  conversion_start,
    input  wire logic                  conv_done,
    output logic                       conv_go,
    output logic                       conv_abort,
    // analog control
    output logic      [1:0]            chan_sel,
    output logic      [DAC_W-1:0]      ref_dac_code,
    output logic                       deep_pd,
    output logic                       nap_pd,
    output logic                       analog_ready,
    output logic                       iface_busy
);
    import arpd_pkg::*;
    if (DEEP_WAKE < 1 || DEEP_WAKE > 65535)
    begin : g_param_chk
        $error("DEEP_WAKE must be 1 to 65535 cycles");
    end

    logic [DB_W-1:0]  cfg_r;
    logic [DB_W-1:0]  reference_dac_code_r;
    logic [DB_W-1:0]  seq_r;
    logic [1:0]       slot_r;
    arpd_next_type    next_r;
    arpd_rd_type      rd_r;
    logic             wr_d_r;
    logic             rd_d_r;
    logic             cs_d_r;
    logic             deep_bit_r;
    logic             nap_bit_r;
    logic             deep_pd_r;
    logic             nap_pd_r;
    logic             anap_pd_r;
    logic [15:0]      wake_cnt_r;
    logic [2:0]       go_cnt_r;
    logic [2:0]       rst_cnt_r;
    logic [DB_W-1:0]  db_out_r;
    logic             db_oe_r;
    logic             abort_r;
    logic             go_r;
    logic             busy_r;
    logic             nap_out_r;

    wire              wr_rise   = ~wr_d_r & wr_n;
    wire              rd_fall   = rd_d_r & ~rd_n;
    wire              cs_fall   = cs_d_r & ~conversion_start;
    wire              live      = (rst_cnt_r == 3'h0);
    wire [2:0]        act       = db_in[A_LSB+2:A_LSB];
    wire              ext_sel   = db_in[R_LSB+1:R_LSB] == R_SEL_EXT;
    wire              cfg_wr    = wr_rise & live & (next_r == ARPD_NEXT_CFG);
    wire              do_swrst  = cfg_wr & (act == ACT_SWRESET);
    wire [1:0]        seq_len   = seq_r[SL_LSB+1:SL_LSB];
    wire              seq_on    = seq_len != 2'h0;
    wire              pd_now    = deep_pd_r | nap_pd_r;
    wire [1:0]        slot_next = (slot_r >= seq_len) ? 2'h1 : slot_r + 2'h1;
    wire [1:0]        slot_ch   = slot_r == 2'h1 ? seq_r[7:6] :
                                  slot_r == 2'h2 ? seq_r[5:4] : seq_r[3:2];

    // configuration, dac and sequencer registers; power-down leaves them alone
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r                <= 12'h000;
            reference_dac_code_r <= DAC_RESET;
            seq_r                <= SEQ_RESET;
            next_r               <= ARPD_NEXT_CFG;
            rd_r                 <= ARPD_RD_CONV;
        end
        else if (do_swrst)
        begin
            cfg_r                <= 12'h000;
            reference_dac_code_r <= DAC_RESET;
            seq_r                <= SEQ_RESET;
            next_r               <= ARPD_NEXT_CFG;
            rd_r                 <= ARPD_RD_CONV;
        end
        else if (wr_rise && live)
        begin
            unique case (next_r)
                ARPD_NEXT_DAC_WR:
                begin
                    reference_dac_code_r <= {2'h0, db_in[DAC_W-1:0]};
                    next_r               <= ARPD_NEXT_CFG;
                end
                ARPD_NEXT_SEQ_WR:
                begin
                    seq_r  <= {db_in[DB_W-1:2], 2'h0};
                    next_r <= ARPD_NEXT_CFG;
                end
                ARPD_NEXT_CFG:
                begin
                    cfg_r <= db_in;
                    rd_r  <= ARPD_RD_CONV;
                    if (ext_sel && act == ACT_DAC_WR) next_r <= ARPD_NEXT_DAC_WR;
                    if (ext_sel && act == ACT_SEQ_WR) next_r <= ARPD_NEXT_SEQ_WR;
                    if (ext_sel && act == ACT_DAC_RD) rd_r <= ARPD_RD_DAC;
                    if (ext_sel && act == ACT_SEQ_RD) rd_r <= ARPD_RD_SEQ;
                end
            endcase
        end
        else if (rd_fall)
            rd_r <= ARPD_RD_CONV;
    end

    // edge capture, sequence position, soft reset hold-off
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_d_r    <= 1'b1;
            rd_d_r    <= 1'b1;
            cs_d_r    <= 1'b1;
            slot_r    <= 2'h0;
            rst_cnt_r <= 3'h0;
            busy_r    <= 1'b0;
        end
        else
        begin
            wr_d_r    <= wr_n;
            rd_d_r    <= rd_n;
            cs_d_r    <= conversion_start;
            rst_cnt_r <= do_swrst ? 3'(SWRST_CYC) : (live ? 3'h0 : rst_cnt_r - 3'h1);
            busy_r    <= do_swrst | (rst_cnt_r > 3'h1);
            if (do_swrst || !seq_on)
                slot_r <= 2'h0;
            else if (slot_r == 2'h0)
                slot_r <= 2'h1;
            else if (cs_fall && !pd_now)
                slot_r <= slot_next;
        end
    end

    // power-down: deep and nap act on the write edge after their bits are set, auto-nap on conv_done
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            deep_bit_r <= 1'b0;
            nap_bit_r  <= 1'b0;
            deep_pd_r  <= 1'b0;
            nap_pd_r   <= 1'b0;
            anap_pd_r  <= 1'b0;
            wake_cnt_r <= 16'h0000;
            go_cnt_r   <= 3'h0;
            abort_r    <= 1'b0;
            go_r       <= 1'b0;
        end
        else
        begin
            abort_r <= 1'b0;
            go_r    <= 1'b0;
            if (do_swrst)
            begin
                deep_bit_r <= 1'b0;
                nap_bit_r  <= 1'b0;
                deep_pd_r  <= 1'b0;
                nap_pd_r   <= 1'b0;
                anap_pd_r  <= 1'b0;
                go_cnt_r   <= 3'h0;
                wake_cnt_r <= 16'h0000;
            end
            else
            begin
                if (cfg_wr)
                begin
                    deep_bit_r <= db_in[DEEP_BIT];
                    nap_bit_r  <= db_in[NAP_BIT];
                end
                if (wr_rise && live && deep_bit_r && !deep_pd_r)
                begin
                    deep_pd_r <= 1'b1;
                    abort_r   <= 1'b1;
                end
                if (wr_rise && live && nap_bit_r && !nap_pd_r)
                begin
                    nap_pd_r <= 1'b1;
                    abort_r  <= 1'b1;
                end
                if (cfg_wr && !db_in[DEEP_BIT] && deep_pd_r)
                begin
                    deep_pd_r  <= 1'b0;
                    wake_cnt_r <= 16'(DEEP_WAKE);
                end
                else if (cfg_wr && !db_in[NAP_BIT] && nap_pd_r)
                begin
                    nap_pd_r   <= 1'b0;
                    wake_cnt_r <= 16'(NAP_WAKE_CLK);
                end
                else if (wake_cnt_r != 16'h0000)
                    wake_cnt_r <= wake_cnt_r - 16'h0001;
                if (cfg_r[ANAP_BIT] && conv_done)
                    anap_pd_r <= 1'b1;
                else if (!cfg_r[ANAP_BIT])
                    anap_pd_r <= 1'b0;
                if (cs_fall && !pd_now && anap_pd_r)
                begin
                    anap_pd_r <= 1'b0;
                    go_cnt_r  <= 3'(NAP_WAKE_CLK);
                end
                else if (cs_fall && !pd_now && wake_cnt_r == 16'h0000)
                    go_r <= 1'b1;
                else if (go_cnt_r != 3'h0)
                begin
                    go_cnt_r <= go_cnt_r - 3'h1;
                    go_r     <= go_cnt_r == 3'h1;
                end
            end
        end
    end

    // read-back and analog outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            db_out_r <= 12'h000;
            db_oe_r  <= 1'b0;
        end
        else
        begin
            db_oe_r <= ~rd_n & (rd_fall ? (rd_r != ARPD_RD_CONV) : db_oe_r);
            if (rd_fall)
                db_out_r <= rd_r == ARPD_RD_DAC ? {2'h0, reference_dac_code_r[DAC_W-1:0]}
                          : rd_r == ARPD_RD_SEQ ? {seq_r[DB_W-1:2], slot_r} : 12'h000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_sel     <= 2'h0;
            ref_dac_code <= DAC_RESET[DAC_W-1:0];
            analog_ready <= 1'b1;
            nap_out_r    <= 1'b0;
        end
        else
        begin
            chan_sel     <= seq_on ? slot_ch : cfg_r[CH_LSB+1:CH_LSB];
            ref_dac_code <= reference_dac_code_r[DAC_W-1:0];
            analog_ready <= ~pd_now & ~anap_pd_r & (wake_cnt_r == 16'h0000) & (go_cnt_r == 3'h0);
            nap_out_r    <= nap_pd_r | anap_pd_r;
        end
    end

    assign db_out     = db_out_r;
    assign db_oe      = db_oe_r;
    assign conv_go    = go_r;
    assign conv_abort = abort_r;
    assign deep_pd    = deep_pd_r;
    assign nap_pd     = nap_out_r;
    assign iface_busy = busy_r;
endmodule : arpd_ctrl

// file: arpd_ctrl_assertions.sv
// checker: timing relations at the control block ports
`timescale 1ns/1ps
module arpd_ctrl_assertions
    import arpd_pkg::*;
#(
    parameter int DEEP_WAKE = DEEP_WAKE_CYC
)(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             rst_n,
    // parallel interface
    input wire logic             rd_n,
    input wire logic             db_oe,
    // conversion and analog control
    input wire logic             conv_abort,
    input wire logic [1:0]       chan_sel,
    input wire logic [DAC_W-1:0] ref_dac_code,
    input wire logic             deep_pd,
    input wire logic             nap_pd,
    input wire logic             analog_ready,
    input wire logic             iface_busy
);
    localparam int DW_MAX = DEEP_WAKE + 4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RST_VAL: assert property ($rose(rst_n) |-> ref_dac_code == 10'h3FF && analog_ready)
        else $error("reset values wrong");
    AST_OE_RD: assert property (db_oe |-> !$past(rd_n))
        else $error("bus driven without read strobe");
    AST_DEEP_READY: assert property (deep_pd [*3] |-> !analog_ready)
        else $error("ready during deep power-down");
    AST_NAP_READY: assert property (nap_pd [*3] |-> !analog_ready)
        else $error("ready during nap");
    AST_NAP_WAKE: assert property ($fell(nap_pd) && !deep_pd |-> ##[1:10] analog_ready)
        else $error("nap wake too slow");
    AST_DEEP_WAKE: assert property ($fell(deep_pd) |-> ##[1:DW_MAX] analog_ready)
        else $error("deep wake too slow");
    AST_BUSY_LEN: assert property ($rose(iface_busy) |-> iface_busy [*3] ##1 !iface_busy)
        else $error("interface hold-off length wrong");
    AST_SWRST_DAC: assert property ($rose(iface_busy) |-> ##[0:3]
        (ref_dac_code == 10'h3FF && chan_sel == 2'h0))
        else $error("soft reset left settings");
    AST_ABORT: assert property (conv_abort |-> ##[0:2] (deep_pd || nap_pd))
        else $error("abort without power-down");
    AST_PD_KEEP: assert property (($rose(deep_pd) || $rose(nap_pd)) |->
        $stable(ref_dac_code) && $stable(chan_sel))
        else $error("power-down changed settings");
    cover property ($rose(nap_pd));
    cover property ($rose(deep_pd));
    cover property ($rose(iface_busy));
    cover property (conv_abort);
endmodule : arpd_ctrl_assertions

bind arpd_ctrl arpd_ctrl_assertions #(.DEEP_WAKE(DEEP_WAKE)) chk_u (.ref_clk, .rst_n, .rd_n,
    .db_oe, .conv_abort, .chan_sel, .ref_dac_code, .deep_pd, .nap_pd, .analog_ready, .iface_busy);

// file: arpd_host.sv
// host model: parallel write and read strobes and conversion start
`timescale 1ns/1ps
module arpd_host
    import arpd_pkg::*;
(
    // clock
    input wire logic       ref_clk,
    // parallel interface
    output logic            wr_n,
    output logic            rd_n,
    output logic [DB_W-1:0] db_in,
    input wire logic [DB_W-1:0] db_out,
    input wire logic        db_oe,
    // conversion start
    output logic            conversion_start
);
    initial
    begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        db_in = 12'h000;
        conversion_start = 1'b1;
    end
    task write(input logic [DB_W-1:0] d);
        @(posedge ref_clk);
        wr_n <= 1'b0;
        db_in <= d;
        repeat (2) @(posedge ref_clk);
        wr_n <= 1'b1;
        @(posedge ref_clk);
        db_in <= ~d;
        repeat (5) @(posedge ref_clk);
    endtask : write
    task read(output logic [DB_W-1:0] d, output logic oe);
        @(posedge ref_clk);
        rd_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        d = db_out;
        oe = db_oe;
        rd_n <= 1'b1;
        @(posedge ref_clk);
    endtask : read
    task start();
        @(posedge ref_clk);
        conversion_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        conversion_start <= 1'b1;
    endtask : start
endmodule : arpd_host

// file: arpd_pkg.sv
// package: constants for the reference dac, power-down and reset control
package arpd_pkg;
    localparam int          DB_W          = 12;
    localparam int          DAC_W         = 10;
    localparam logic [11:0] DAC_RESET     = 12'h3FF;
    localparam logic [11:0] SEQ_RESET     = 12'h000;
    // control word fields
    localparam int          A_LSB         = 0;
    localparam int          R_LSB         = 3;
    localparam int          CH_LSB        = 5;
    localparam int          DEEP_BIT      = 7;
    localparam int          NAP_BIT       = 8;
    localparam int          ANAP_BIT      = 9;
    localparam logic [1:0]  R_SEL_EXT     = 2'h1;
    localparam logic [2:0]  ACT_DAC_WR    = 3'h1;
    localparam logic [2:0]  ACT_DAC_RD    = 3'h3;
    localparam logic [2:0]  ACT_SEQ_WR    = 3'h4;
    localparam logic [2:0]  ACT_SWRESET   = 3'h5;
    localparam logic [2:0]  ACT_SEQ_RD    = 3'h6;
    // sequencer field positions
    localparam int          SL_LSB        = 8;
    localparam int          SEQ_MODE_BIT  = 11;
    // timing
    localparam int          CLK_PERIOD_PS = 8000;
    localparam int          DEEP_ACT_NS   = 2000;
    localparam int          DEEP_WAKE_NS  = 1000;
    localparam int          NAP_ACT_NS    = 200;
    localparam int          SWRST_NS      = 20;
    localparam int          NAP_WAKE_CLK  = 6;
    localparam int          CONV_CLK      = 22;
    localparam int          DEEP_ACT_CYC  = (DEEP_ACT_NS * 1000) / CLK_PERIOD_PS;
    localparam int          DEEP_WAKE_CYC = (DEEP_WAKE_NS * 1000) / CLK_PERIOD_PS;
    localparam int          NAP_ACT_CYC   = (NAP_ACT_NS * 1000) / CLK_PERIOD_PS;
    localparam int          SWRST_CYC     = (SWRST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [1:0] {ARPD_NEXT_CFG, ARPD_NEXT_DAC_WR, ARPD_NEXT_SEQ_WR} arpd_next_type;
    typedef enum logic [1:0] {ARPD_RD_CONV, ARPD_RD_DAC, ARPD_RD_SEQ} arpd_rd_type;
endpackage : arpd_pkg

// file: tb_adc_refdac_powerdown_ctrl.sv
// testbench: dac load and read, power-down modes and soft reset
`timescale 1ns/1ps
module tb_adc_refdac_powerdown_ctrl;
    import arpd_pkg::*;
    localparam int DW = 2;
    localparam logic [2:0] OTHER [3] = '{3'h0, 3'h2, 3'h7};
    logic             ref_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             conv_done = 1'b0;
    logic             wr_n, rd_n, conversion_start, db_oe, conv_go, conv_abort, oe;
    logic             deep_pd, nap_pd, analog_ready, iface_busy;
    logic [DB_W-1:0]  db_in, db_out, rd_val;
    logic [1:0]       chan_sel;
    logic [DAC_W-1:0] ref_dac_code;
    int               err_count = 0;
    int               total_checks = 0;
    int               n;
    always #4 ref_clk = ~ref_clk;
    arpd_ctrl #(.DEEP_WAKE(DW)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wr_n(wr_n),
        .rd_n(rd_n), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
        .conversion_start(conversion_start), .conv_done(conv_done), .conv_go(conv_go),
        .conv_abort(conv_abort), .chan_sel(chan_sel), .ref_dac_code(ref_dac_code),
        .deep_pd(deep_pd), .nap_pd(nap_pd), .analog_ready(analog_ready), .iface_busy(iface_busy));
    arpd_host host_u (.ref_clk(ref_clk), .wr_n(wr_n), .rd_n(rd_n), .db_in(db_in),
        .db_out(db_out), .db_oe(db_oe), .conversion_start(conversion_start));
    function automatic logic [DB_W-1:0] cfg(input logic [2:0] pd, input logic [1:0] ch,
                                            input logic [2:0] act);
        return {2'h0, pd, ch, R_SEL_EXT, act};
    endfunction : cfg
    task complete_run();
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task chk(input logic [DB_W-1:0] got, input logic [DB_W-1:0] exp);
        #1;
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk1(input logic got, input logic exp);
        chk({11'h0, got}, {11'h0, exp});
    endtask : chk1
    task to_check(input int cnt);
        if (cnt >= 40)
        begin
            err_count++;
            $display("Error at %0t: wait ran out", $time);
            complete_run();
        end
    endtask : to_check
    task read_back(input logic [2:0] act, input logic [DB_W-1:0] exp);
        host_u.write(cfg(3'h0, 2'h0, act));
        host_u.read(rd_val, oe);
        chk(rd_val, exp);
        chk1(oe, 1'b1);
    endtask : read_back
    task reset_values();
        chk({2'h0, ref_dac_code}, DAC_RESET);
        chk1(analog_ready, 1'b1);
        read_back(ACT_DAC_RD, DAC_RESET);
        host_u.write(cfg(3'h0, 2'h0, ACT_SEQ_RD));
        host_u.read(rd_val, oe);
        chk({10'h0, rd_val[1:0]}, 12'h000);
    endtask : reset_values
    task dac_load();
        host_u.write(cfg(3'h0, 2'h2, ACT_DAC_WR));
        chk({2'h0, ref_dac_code}, DAC_RESET);
        host_u.write(12'h2A5);
        chk({2'h0, ref_dac_code}, 12'h2A5);
        for (int i = 0; i < 3; i++)
        begin
            host_u.write(cfg(3'h0, 2'(i), OTHER[i]));
            chk({10'h0, chan_sel}, 12'(i));
            chk({2'h0, ref_dac_code}, 12'h2A5);
        end
        read_back(ACT_DAC_RD, 12'h2A5);
    endtask : dac_load
    task pd_cycle(input logic [2:0] pd, input int wake);
        host_u.write(cfg(pd, 2'h1, 3'h0));
        chk1(deep_pd | nap_pd, 1'b0);
        host_u.start();
        host_u.write(cfg(pd, 2'h1, 3'h0));
        chk1(pd[0] ? deep_pd : nap_pd, 1'b1);
        chk1(analog_ready, 1'b0);
        chk({10'h0, chan_sel}, 12'h001);
        chk({2'h0, ref_dac_code}, 12'h2A5);
        host_u.write(cfg(3'h0, 2'h1, 3'h0));
        chk1(deep_pd | nap_pd, 1'b0);
        chk1(analog_ready, wake < 5);
        repeat (wake) @(posedge ref_clk);
        chk1(analog_ready, 1'b1);
    endtask : pd_cycle
    task auto_nap();
        host_u.write(cfg(3'h4, 2'h0, 3'h0));
        host_u.write(cfg(3'h4, 2'h0, 3'h0));
        conv_done <= 1'b1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        for (n = 0; n < 40 && nap_pd !== 1'b1; n++) @(posedge ref_clk);
        to_check(n);
        chk1(n <= NAP_ACT_CYC, 1'b1);
        host_u.start();
        for (n = 0; n < 40 && conv_go !== 1'b1; n++) @(posedge ref_clk);
        to_check(n);
        chk1(n == NAP_WAKE_CLK - 1, 1'b1);
        host_u.write(cfg(3'h0, 2'h0, 3'h0));
    endtask : auto_nap
    task seq_run();
        host_u.write(cfg(3'h0, 2'h0, ACT_SEQ_WR));
        host_u.write(12'h260);
        read_back(ACT_SEQ_RD, 12'h261);
        chk({10'h0, chan_sel}, 12'h001);
        host_u.start();
        chk({10'h0, chan_sel}, 12'h002);
        read_back(ACT_SEQ_RD, 12'h262);
        host_u.start();
        read_back(ACT_SEQ_RD, 12'h261);
    endtask : seq_run
    task soft_reset();
        host_u.write(cfg(3'h0, 2'h3, ACT_SWRESET));
        chk({2'h0, ref_dac_code}, DAC_RESET);
        chk({10'h0, chan_sel}, 12'h000);
        read_back(ACT_DAC_RD, DAC_RESET);
        read_back(ACT_SEQ_RD, SEQ_RESET);
    endtask : soft_reset
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        reset_values();
        dac_load();
        pd_cycle(3'h1, DW);
        pd_cycle(3'h2, NAP_WAKE_CLK);
        auto_nap();
        seq_run();
        soft_reset();
        complete_run();
    end
endmodule : tb_adc_refdac_powerdown_ctrl
